// file: inc/cfsc_cfg.svh
// register map, field layout and reset values for the function information
// and digital audio control registers; included by the register block and the bench
`ifndef CFSC_CFG_SVH
`define CFSC_CFG_SVH
`define CFSC_ADDR_FUNC_INFO 7'h68
`define CFSC_ADDR_DIG_CTRL 7'h6A
`define CFSC_ADDR_PAGE_SEL 7'h24
`define CFSC_ADDR_OUT_CTRL 7'h2A
`define CFSC_PAGE_FUNC 16'h0001
`define CFSC_PAGE_DIG 16'h0000
`define CFSC_PAGE_RST 16'h0000
`define CFSC_FI_UPPER_RST 11'h000
`define CFSC_FI_UPPER_LSB 5
`define CFSC_FI_VALID_BIT 4
`define CFSC_DC_OVR_BIT 2
`define CFSC_DC_SRC_BIT 1
`define CFSC_OC_RATE_MASK 16'h3000
`define CFSC_OC_EN_BIT 15
`define CFSC_OC_RST 16'h0000
`define CFSC_GAIN_STEP_CDB 8'h0F
`endif

// file: inc/cfsc_pkg.sv
// types shared by the function information and digital control block
package cfsc_pkg;
    // frame-boundary source switch states
    typedef enum logic [1:0] {
        CFSC_SRC_IDLE = 2'b00,
        CFSC_SRC_WAIT = 2'b01
    } cfsc_src_state_type;
endpackage

// file: design/cfsc_sync.sv
// two-flop synchroniser for single-bit levels from outside the clock domain
// assumes i_srst is synchronous to i_core_clk
`timescale 1ns/1ps
`default_nettype none
module cfsc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_srst,
    // data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // refuse a width the flops cannot hold, at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("cfsc_sync: WIDTH must be at least 1");
    end

    // first flop is read only by the second
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// file: design/cfsc_regs.sv
// function information and digital audio control registers, codec side
// assumes the link frame decoder hands in one-cycle write/read strobes with
// a register address and data, all on i_core_clk; reset pins are async
//
// Overview of operation
// [R1] after link reset, valid flag set if sensing
// [R2] without sensing, valid flag reads 0, read-only
// [R3] write 1 clears; sense completion sets flag
// [R4] writing 0 leaves valid flag unchanged
// [R5] valid flag reset by link reset
// [R6] unused bits always read zero
// [R7] present flag read-only, reports optional fields
// [R8] gain: sign bit plus 1.5 dB steps
// [R9] upper fields R/W, cleared only at power-on
// [R10] digital control reachable only on page 00h
// [R11] override lets output control writes through
// [R12] rate bits stay locked while output enabled
// [R13] sub-code fields change while output runs; here only with override set, else the whole register is locked
// [R14] source select: link PCM or ADC record
// [R15] function information reachable only on page 01h
// [R16] delay field in 48 kHz sample periods
// [R17] source change applied at frame boundary
`timescale 1ns/1ps
`default_nettype none
`include "cfsc_cfg.svh"
module cfsc_regs
    import cfsc_pkg::*;
#(
    parameter bit HAS_SENSE = 1'b1,
    parameter bit FUNC_PRESENT = 1'b1,
    parameter logic [4:0] DELAY_DEFAULT = 5'h01
) (
    // clock and resets
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_por_pin,
    input wire logic i_link_rst_n_pin,
    // register access from the link frame decoder
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [6:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    // sensing and serial output timing
    input wire logic i_sense_done,
    input wire logic i_frame_end,
    // digital output data path
    input wire logic [19:0] i_link_pcm,
    input wire logic [19:0] i_adc_rec,
    output logic [19:0] o_spdif_data,
    output logic o_spdif_src,
    // output control register image and function information gain
    output logic [15:0] o_out_ctrl,
    output logic [8:0] o_gain_cdb
);
    logic por;
    logic link_rst_n;
    logic link_rst_q;
    logic [15:0] page;
    logic [10:0] fi_upper;
    logic valid;
    logic ovr;
    logic src_req;
    logic src_act;
    cfsc_src_state_type src_state;
    logic [15:0] out_ctrl;
    logic link_rel;
    logic fi_hit;
    logic dc_hit;
    logic oc_hit;
    logic oc_locked;

    // delay code 1Fh is reserved; refuse it at elaboration
    if (DELAY_DEFAULT == 5'h1F) begin : g_bad_delay
        $error("cfsc_regs: delay value 1Fh is reserved"); // R16
    end

    // -----------------------------------------------------------------
    // reset pins
    // -----------------------------------------------------------------
    cfsc_sync #(.WIDTH(2)) u_rst_sync (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_async({i_por_pin, i_link_rst_n_pin}),
        .o_sync({por, link_rst_n})
    );

    // link reset release detected on the synchronised level; the history
    // flop resets low on purpose, so leaving i_srst also counts as release
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            link_rst_q <= 1'b0;
        end else begin
            link_rst_q <= link_rst_n;
        end
    end
    assign link_rel = link_rst_n & ~link_rst_q;

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    function automatic logic hit(input logic [6:0] a, input logic [6:0] r,
                                 input logic [15:0] pg,
                                 input logic [15:0] want);
        hit = (a == r) && (pg == want);
    endfunction

    assign fi_hit = hit(i_addr, `CFSC_ADDR_FUNC_INFO, page,
                        `CFSC_PAGE_FUNC); // R15
    assign dc_hit = hit(i_addr, `CFSC_ADDR_DIG_CTRL, page,
                        `CFSC_PAGE_DIG); // R10
    assign oc_hit = (i_addr == `CFSC_ADDR_OUT_CTRL);
    // output enabled and override off locks the whole register
    assign oc_locked = out_ctrl[`CFSC_OC_EN_BIT] & ~ovr;

    // page selector, cleared by either reset
    always_ff @(posedge i_core_clk) begin
        if (i_srst || por || !link_rst_n) begin
            page <= `CFSC_PAGE_RST;
        end else if (i_wr_stb && i_addr == `CFSC_ADDR_PAGE_SEL) begin
            page <= i_wdata;
        end
    end

    // -----------------------------------------------------------------
    // function information
    // -----------------------------------------------------------------
    // upper fields survive link reset so software calibration is kept
    always_ff @(posedge i_core_clk) begin
        if (i_srst || por) begin
            fi_upper <= `CFSC_FI_UPPER_RST; // R9
        end else if (!FUNC_PRESENT) begin
            fi_upper <= {6'h00, DELAY_DEFAULT}; // R7
        end else if (i_wr_stb && fi_hit) begin
            fi_upper <= i_wdata[15:`CFSC_FI_UPPER_LSB]; // R9
        end
    end

    // sense valid flag: set wins over a write-one clear
    always_ff @(posedge i_core_clk) begin
        if (i_srst || !link_rst_n) begin
            valid <= 1'b0; // R5
        end else if (!HAS_SENSE) begin
            valid <= 1'b0; // R2
        end else if (link_rel || i_sense_done) begin
            valid <= 1'b1; // R1 R3
        end else if (i_wr_stb && fi_hit && i_wdata[`CFSC_FI_VALID_BIT]) begin
            valid <= 1'b0; // R3 R4
        end
    end

    // -----------------------------------------------------------------
    // digital audio control
    // -----------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_srst || por || !link_rst_n) begin
            ovr <= 1'b0;
            src_req <= 1'b0;
        end else if (i_wr_stb && dc_hit) begin
            ovr <= i_wdata[`CFSC_DC_OVR_BIT];
            src_req <= i_wdata[`CFSC_DC_SRC_BIT]; // R14
        end
    end

    // source applied only at the frame end, so no sample is split
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            src_act <= 1'b0;
            src_state <= CFSC_SRC_IDLE;
        end else begin
            unique case (src_state)
                CFSC_SRC_IDLE: begin
                    if (src_req != src_act) begin
                        src_state <= CFSC_SRC_WAIT;
                    end
                end
                CFSC_SRC_WAIT: begin
                    if (i_frame_end) begin
                        src_act <= src_req; // R17
                        src_state <= CFSC_SRC_IDLE;
                    end
                end
                default: begin
                    src_state <= CFSC_SRC_IDLE;
                end
            endcase
        end
    end

    // output control write lock with override
    always_ff @(posedge i_core_clk) begin
        if (i_srst || por || !link_rst_n) begin
            out_ctrl <= `CFSC_OC_RST;
        end else if (i_wr_stb && oc_hit && !oc_locked) begin
            if (out_ctrl[`CFSC_OC_EN_BIT]) begin
                // R11 R12 R13
                out_ctrl <= (i_wdata & ~`CFSC_OC_RATE_MASK) |
                            (out_ctrl & `CFSC_OC_RATE_MASK);
            end else begin
                out_ctrl <= i_wdata;
            end
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    // read data; unmapped or wrong page reads zero
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_rdata <= 16'h0000;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd_stb;
            if (i_rd_stb && fi_hit) begin
                // R6 R7
                o_rdata <= {fi_upper, valid, 3'b000, FUNC_PRESENT};
            end else if (i_rd_stb && dc_hit) begin
                o_rdata <= {13'h0000, ovr, src_req, 1'b0}; // R6
            end else if (i_rd_stb && oc_hit) begin
                o_rdata <= out_ctrl;
            end else begin
                o_rdata <= 16'h0000;
            end
        end
    end

    // serial output sample mux, gain in tenths of dB (sign-magnitude)
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_spdif_data <= 20'h00000;
            o_spdif_src <= 1'b0;
            o_out_ctrl <= 16'h0000;
            o_gain_cdb <= 9'h000;
        end else begin
            o_spdif_data <= src_act ? i_adc_rec : i_link_pcm; // R14
            o_spdif_src <= src_act;
            o_out_ctrl <= out_ctrl;
            // R8: magnitude times 15 gives tenths of dB; eight bits, as
            // the top codes run past 127 tenths
            o_gain_cdb <= {fi_upper[10], 8'(fi_upper[9:6] *
                          `CFSC_GAIN_STEP_CDB)};
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_valid_clear: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_wr_stb && fi_hit && i_wdata[4] && !i_sense_done && !link_rel &&
         link_rst_n) |=> !valid) else $error("valid flag not cleared"); // R3
    a_valid_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_wr_stb && fi_hit && !i_wdata[4] && valid && link_rst_n) |=> valid)
        else $error("write of 0 changed valid flag"); // R4
    a_valid_set: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (HAS_SENSE && i_sense_done && link_rst_n) |=> valid)
        else $error("sense completion did not set valid"); // R3
    a_valid_lrst: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !link_rst_n |=> !valid) else $error("valid kept in link reset"); // R5
    a_upper_keep: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (!link_rst_n && !por && !(i_wr_stb && fi_hit)) |=> $stable(fi_upper))
        else $error("upper fields lost in link reset"); // R9
    a_rsvd_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_rd_stb && dc_hit) |=> (o_rdata[15:3] == 13'h0 && !o_rdata[0]))
        else $error("reserved bits not zero"); // R6
    a_rate_lock: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (out_ctrl[15] && link_rst_n && !por) |=>
        (out_ctrl[13:12] == $past(out_ctrl[13:12])))
        else $error("rate bits changed while enabled"); // R12
    a_ovr_write: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_wr_stb && oc_hit && ovr && out_ctrl[15] && link_rst_n && !por)
        |=> (out_ctrl[11:0] == $past(i_wdata[11:0])))
        else $error("override write not taken"); // R11
    a_src_frame: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (src_act != $past(src_act)) |-> $past(i_frame_end))
        else $error("source switched off frame boundary"); // R17
    a_page_gate: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_rd_stb && i_addr == 7'h68 && page != 16'h0001) |=> o_rdata == 0)
        else $error("function info read on wrong page"); // R15
    c_sense: cover property (@(posedge i_core_clk) i_sense_done && valid);
    c_ovr_wr: cover property (@(posedge i_core_clk)
        i_wr_stb && oc_hit && ovr && out_ctrl[15]);
    c_src_sw: cover property (@(posedge i_core_clk)
        src_state == CFSC_SRC_WAIT && i_frame_end);
endmodule
`default_nettype wire

// file: verif/cfsc_ctrl_model.sv
// link controller model: issues register writes and reads on the strobe bus
// assumes the block answers a read with a pulse one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module cfsc_ctrl_model (
    // clock
    input wire logic i_core_clk,
    // register bus
    output logic o_wr_stb,
    output logic o_rd_stb,
    output logic [6:0] o_addr,
    output logic [15:0] o_wdata,
    input wire logic [15:0] i_rdata,
    input wire logic i_rvalid
);
    // idle bus at time zero
    initial begin
        o_wr_stb = 1'b0;
        o_rd_stb = 1'b0;
        o_addr = 7'h00;
        o_wdata = 16'h0000;
    end

    // one write; callers select the page at 24h first
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        o_wr_stb <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_core_clk);
        o_wr_stb <= 1'b0;
        o_addr <= ~a; // released bus shows no stale value
        o_wdata <= ~d;
    endtask

    // one read; ok stays low when no answer comes within the bound
    task automatic rd(input logic [6:0] a, output logic [15:0] d,
                      output bit ok);
        @(posedge i_core_clk);
        o_rd_stb <= 1'b1;
        o_addr <= a;
        @(posedge i_core_clk);
        o_rd_stb <= 1'b0;
        o_addr <= ~a;
        ok = 1'b0;
        d = 16'h0000;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge i_core_clk);
            if (i_rvalid === 1'b1) begin
                ok = 1'b1;
                d = i_rdata;
            end
        end
    endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the function information and digital control
// registers; the controller model drives the register strobes
`timescale 1ns/1ps
`default_nettype none
`include "cfsc_cfg.svh"
module tb_top;
    localparam logic [6:0] FI = `CFSC_ADDR_FUNC_INFO;
    localparam logic [6:0] DC = `CFSC_ADDR_DIG_CTRL;
    localparam logic [6:0] PG = `CFSC_ADDR_PAGE_SEL;
    localparam logic [6:0] OC = `CFSC_ADDR_OUT_CTRL;
    logic i_core_clk, i_srst, i_por_pin, i_link_rst_n_pin;
    logic wr_stb, rd_stb, rvalid, sense_done, frame_end, spdif_src;
    logic [6:0] addr;
    logic [15:0] wdata, rdata, out_ctrl;
    logic [19:0] link_pcm, adc_rec, spdif_data;
    logic [8:0] gain_cdb;
    int miscompares = 0;
    int n_compared = 0;

    cfsc_ctrl_model ctl_u (.i_core_clk(i_core_clk), .o_wr_stb(wr_stb),
        .o_rd_stb(rd_stb), .o_addr(addr), .o_wdata(wdata),
        .i_rdata(rdata), .i_rvalid(rvalid));
    cfsc_regs dut_u (.i_core_clk(i_core_clk), .i_srst(i_srst),
        .i_por_pin(i_por_pin), .i_link_rst_n_pin(i_link_rst_n_pin),
        .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .i_addr(addr),
        .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_sense_done(sense_done), .i_frame_end(frame_end),
        .i_link_pcm(link_pcm), .i_adc_rec(adc_rec),
        .o_spdif_data(spdif_data), .o_spdif_src(spdif_src),
        .o_out_ctrl(out_ctrl), .o_gain_cdb(gain_cdb));

    // 100 MHz clock
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    // read and compare; a missing answer ends the run
    task automatic rchk(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] d;
        bit ok;
        ctl_u.rd(a, d, ok);
        if (!ok) begin
            miscompares++;
            $display("ERROR %0t no read answer", $time);
            complete_run();
        end else begin
            chk({4'h0, d}, {4'h0, e});
        end
    endtask
    // one-cycle pulse on a sense or frame strobe
    task automatic pulse(input bit frame);
        @(posedge i_core_clk);
        if (frame) frame_end <= 1'b1;
        else sense_done <= 1'b1;
        @(posedge i_core_clk);
        frame_end <= 1'b0;
        sense_done <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rchk(DC, 16'h0000);
        ctl_u.wr(PG, 16'h0001);
        rchk(FI, 16'h0011);
        chk({4'h0, out_ctrl}, 20'h00000);
        $display("reset values done");
    endtask
    task automatic t_valid();
        ctl_u.wr(FI, 16'hFFEE); // zero to the flag, ones to reserved bits
        rchk(FI, 16'hFFF1);
        ctl_u.wr(FI, 16'h0800);
        tick(2);
        chk({11'h000, gain_cdb}, 20'h0000F);
        ctl_u.wr(FI, 16'hD000); // attenuation, magnitude 10: 15.0 dB
        tick(2);
        chk({11'h000, gain_cdb}, 20'h00196);
        ctl_u.wr(FI, 16'h8810);
        rchk(FI, 16'h8801);
        chk({11'h000, gain_cdb}, 20'h0010F);
        pulse(1'b0);
        tick(1);
        rchk(FI, 16'h8811);
        $display("valid flag done");
    endtask
    task automatic t_page();
        ctl_u.wr(DC, 16'h0006);
        rchk(DC, 16'h0000);
        rchk(7'h10, 16'h0000);
        ctl_u.wr(PG, 16'h0000);
        ctl_u.wr(FI, 16'h0000);
        rchk(FI, 16'h0000);
        ctl_u.wr(PG, 16'h0001);
        rchk(FI, 16'h8811);
        ctl_u.wr(PG, 16'h0000);
        $display("paging done");
    endtask
    task automatic t_src();
        ctl_u.wr(DC, 16'hFFFF);
        rchk(DC, 16'h0006);
        chk({19'h0, spdif_src}, 20'h0);
        chk(spdif_data, link_pcm);
        pulse(1'b1);
        tick(2);
        chk({19'h0, spdif_src}, 20'h1);
        chk(spdif_data, adc_rec);
        $display("source select done");
    endtask
    task automatic t_lock();
        ctl_u.wr(DC, 16'h0000);
        ctl_u.wr(OC, 16'h8000);
        tick(2);
        chk({4'h0, out_ctrl}, 20'h08000);
        ctl_u.wr(OC, 16'hBF0F);
        tick(2);
        chk({4'h0, out_ctrl}, 20'h08000);
        ctl_u.wr(DC, 16'h0004);
        ctl_u.wr(OC, 16'hB0FF);
        tick(2);
        chk({4'h0, out_ctrl}, 20'h080FF);
        ctl_u.wr(OC, 16'h3000);
        tick(2);
        chk({4'h0, out_ctrl}, 20'h00000);
        ctl_u.wr(OC, 16'h3000);
        tick(2);
        chk({4'h0, out_ctrl}, 20'h03000);
        $display("output lock done");
    endtask
    task automatic t_resets();
        ctl_u.wr(PG, 16'h0001);
        ctl_u.wr(FI, 16'h8810);
        i_link_rst_n_pin <= 1'b0;
        tick(5);
        i_link_rst_n_pin <= 1'b1;
        tick(5);
        rchk(DC, 16'h0000);
        ctl_u.wr(PG, 16'h0001);
        rchk(FI, 16'h8811);
        i_por_pin <= 1'b1;
        tick(5);
        i_por_pin <= 1'b0;
        tick(5);
        ctl_u.wr(PG, 16'h0001);
        rchk(FI, 16'h0011);
        $display("reset domains done");
    endtask

    // main sequence
    initial begin
        i_srst = 1'b1;
        i_por_pin = 1'b1;
        i_link_rst_n_pin = 1'b1;
        sense_done = 1'b0;
        frame_end = 1'b0;
        link_pcm = 20'h12345;
        adc_rec = 20'hABCDE;
        tick(12);
        i_srst <= 1'b0;
        i_por_pin <= 1'b0;
        tick(4); // pin synchronisers settle
        t_reset();
        t_valid();
        t_page();
        t_src();
        t_lock();
        t_resets();
        complete_run();
    end
endmodule
`default_nettype wire
